// >>> hw/rsp_port.sv
// Purpose: Slave serial port with config, status, strobes, queue, table
// Assumes: Host clock idles low between frames and stops outside them
// Notes:   Status snapshot freezes while selected so the link reads it
//          as stable bundled data; radio core owns the state machine
module rsp_port
   import rsp_pkg::*;
(
   input  wire logic                      clock,
   input  wire logic                      nrst,
   input  wire logic                      sclk,
   input  wire logic                      csn,
   input  wire logic                      si,
   input  wire logic                      osc_ready_low,
   input  wire logic [2:0]                radio_state,
   input  wire logic [STAT_REGS-1:0][7:0] status_regs,
   input  wire logic                      sleep_enter,
   input  wire logic                      tx_pop,
   input  wire logic                      ook_mode,
   input  wire logic                      ook_bit,
   input  wire logic [2:0]                power_select_field,
   output logic                           so_out,
   output logic                           so_oe,
   output rsp_cfg_wr_s                    cfg_wr,
   output logic                           strobe_valid,
   output logic [ADDR_W-1:0]              strobe_code,
   output logic                           flush_done,
   output logic                           power_down_req,
   output logic                           osc_off_req,
   output logic                           chip_reset_req,
   output logic [7:0]                     tx_data,
   output logic                           tx_empty,
   output logic [7:0]                     pa_level
);

   // ------------------------------------------------------------
   // Core-domain synchronisers
   // ------------------------------------------------------------
   logic      csn_s1, csn_s2, rdy_s1, rdy_s2, tog_s1, tog_s2;
   logic      tog_link;
   rsp_evt_s  ev_link;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         csn_s1 <= 1'b1;
         csn_s2 <= 1'b1;
         rdy_s1 <= 1'b1;
         rdy_s2 <= 1'b1;
         tog_s1 <= 1'b0;
         tog_s2 <= 1'b0;
      end else begin
         csn_s1 <= csn;
         csn_s2 <= csn_s1;
         rdy_s1 <= osc_ready_low;
         rdy_s2 <= rdy_s1;
         tog_s1 <= tog_link;
         tog_s2 <= tog_s1;
      end
   end

   // ------------------------------------------------------------
   // Core-domain control, queue and table mirror
   // ------------------------------------------------------------
   logic [7:0]        fifo_mem [FIFO_DEPTH];
   logic [7:0]        pa_mirror [PA_DEPTH];
   logic [5:0]        wp, rp, next_wp, next_rp;
   logic [CNT_W-1:0]  cnt, next_cnt;
   logic              tog_seen, next_tog_seen;
   logic              pend_pd, pend_xo, next_pend_pd, next_pend_xo;
   logic              por, cfg_rst, pa_rst;
   logic              next_cfg_rst, next_pa_rst;
   logic              rdy_q;
   rsp_snap_s         snap, next_snap;
   rsp_cfg_wr_s       next_cfg_wr;
   logic              next_stb_v, next_flush, next_pd, next_xo, next_rst;
   logic [ADDR_W-1:0] next_stb_code;
   logic [7:0]        next_tx_data, next_pa_level;
   logic              evt_new, push, pop, flush, pa_we_core;

   always_comb begin
      evt_new       = tog_s2 ^ tog_seen;
      next_tog_seen = tog_s2;
      next_cfg_wr   = '0;
      next_stb_v    = 1'b0;
      next_stb_code = strobe_code;
      next_flush    = 1'b0;
      next_pd       = 1'b0;
      next_xo       = 1'b0;
      next_rst      = 1'b0;
      next_pend_pd  = pend_pd;
      next_pend_xo  = pend_xo;
      push          = 1'b0;
      flush         = sleep_enter;                          // R18
      pa_we_core    = 1'b0;
      if (evt_new) begin
         case (ev_link.kind)
            EV_CFG: begin
               next_cfg_wr = '{valid: 1'b1, addr: ev_link.addr,
                               data: ev_link.data};
            end
            EV_PA: pa_we_core = 1'b1;
            EV_FIFO: push = (cnt < FIFO_FULL);
            EV_STROBE: begin
               next_stb_v    = 1'b1;
               next_stb_code = ev_link.addr;
               if (ev_link.addr == STB_CHIP_RST)
                  next_rst = 1'b1;
               if (ev_link.addr == STB_FLUSH_TX &&
                   (radio_state == RS_IDLE ||
                    radio_state == RS_UNDERFLOW)) begin     // R18
                  flush      = 1'b1;
                  next_flush = 1'b1;
               end
               // Held until the host lets go of the port
               if (ev_link.addr == STB_PWR_DOWN)
                  next_pend_pd = 1'b1;                      // R14
               if (ev_link.addr == STB_OSC_OFF)
                  next_pend_xo = 1'b1;                      // R14
            end
            default: ;
         endcase
      end
      if (csn_s2 && !evt_new) begin
         next_pd      = pend_pd;                            // R14
         next_xo      = pend_xo;                            // R14
         next_pend_pd = 1'b0;
         next_pend_xo = 1'b0;
      end
      pop     = tx_pop && (cnt != '0);
      next_wp = wp;
      next_rp = rp;
      next_cnt = cnt;
      next_tx_data = tx_data;
      if (pop) begin
         next_tx_data = fifo_mem[rp];
         next_rp      = rp + 6'h01;
      end
      if (push)
         next_wp = wp + 6'h01;
      next_cnt = cnt + CNT_W'(push) - CNT_W'(pop);
      if (flush) begin
         next_wp  = '0;
         next_rp  = '0;
         next_cnt = '0;
      end
      next_cfg_rst = next_rst;
      next_pa_rst  = next_rst | sleep_enter;                // R22
      // Frozen while selected: link samples it without a handshake
      next_snap = snap;
      if (csn_s2)
         next_snap = '{rdy_low: rdy_s2, state: radio_state,
                       free: FIFO_FULL - cnt, stat: status_regs};
      next_pa_level = pa_mirror[(ook_mode && ook_bit) ?
                                power_select_field : 3'h0]; // R21
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         tog_seen       <= 1'b0;
         wp             <= '0;
         rp             <= '0;
         cnt            <= '0;
         pend_pd        <= 1'b0;
         pend_xo        <= 1'b0;
         por            <= 1'b1;
         cfg_rst        <= 1'b1;
         pa_rst         <= 1'b1;
         rdy_q          <= 1'b1;
         snap           <= '{rdy_low: 1'b1, state: RS_IDLE,
                             free: FIFO_FULL, stat: '0};
         cfg_wr         <= '0;
         strobe_valid   <= 1'b0;
         strobe_code    <= '0;
         flush_done     <= 1'b0;
         power_down_req <= 1'b0;
         osc_off_req    <= 1'b0;
         chip_reset_req <= 1'b0;
         tx_data        <= '0;
         tx_empty       <= 1'b1;
         pa_level       <= PA_RESET;
         so_oe          <= 1'b0;
      end else begin
         tog_seen       <= next_tog_seen;
         wp             <= next_wp;
         rp             <= next_rp;
         cnt            <= next_cnt;
         pend_pd        <= next_pend_pd;
         pend_xo        <= next_pend_xo;
         por            <= 1'b0;
         cfg_rst        <= next_cfg_rst;
         pa_rst         <= next_pa_rst;
         rdy_q          <= rdy_s2;                          // R2
         snap           <= next_snap;
         cfg_wr         <= next_cfg_wr;
         strobe_valid   <= next_stb_v;
         strobe_code    <= next_stb_code;
         flush_done     <= next_flush;
         power_down_req <= next_pd;
         osc_off_req    <= next_xo;
         chip_reset_req <= next_rst;
         tx_data        <= next_tx_data;
         tx_empty       <= (next_cnt == '0);
         pa_level       <= next_pa_level;
         so_oe          <= !csn_s2;                         // R26
      end
   end

   always_ff @(posedge clock) begin
      if (push)
         fifo_mem[wp] <= ev_link.data;
      for (int i = 0; i < PA_DEPTH; i++) begin
         if (!nrst || next_pa_rst)
            pa_mirror[i] <= PA_RESET;                       // R22
         else if (pa_we_core && ev_link.addr[2:0] == 3'(i))
            pa_mirror[i] <= ev_link.data;
      end
   end

   // ------------------------------------------------------------
   // Link domain: frame state cleared while deselected, event toggle, register stores
   // ------------------------------------------------------------
   logic [7:0]        cfg_mem [CFG_REGS];
   logic [7:0]        pa_mem [PA_DEPTH];
   logic [2:0]        bit_cnt, next_bit_cnt, pa_idx, next_pa_idx;
   logic [6:0]        shin, next_shin;
   logic              hdr_valid, rw, burst;
   logic              next_hdr_valid, next_rw, next_burst;
   logic [ADDR_W-1:0] addr, next_addr;
   logic [CNT_W-1:0]  written, next_written;
   logic [7:0]        rd_byte, next_rd_byte, rx, status_now, out_cur;
   logic              ev_fire, cfg_we, pa_we;
   rsp_evt_s          ev_next;

   // Read data for an address; unmapped and write-only read as zero
   function automatic logic [7:0] rd_mux(input logic [ADDR_W-1:0] a,
                                         input logic              b,
                                         input logic [2:0]        idx);
      logic [ADDR_W-1:0] s;
      s = a - STAT_FIRST;
      rd_mux = 8'h00;
      if (a <= CFG_LAST)
         rd_mux = cfg_mem[a];                               // R5
      else if (rsp_is_stat(a) && b)
         rd_mux = snap.stat[s[3:0]];                        // R11
      else if (a == PA_ADDR)
         rd_mux = pa_mem[idx];                              // R20
   endfunction

   always_comb begin
      rx             = {shin, si};                          // R7
      next_bit_cnt   = bit_cnt + 3'h1;                      // R10
      next_shin      = rx[6:0];
      next_hdr_valid = hdr_valid;
      next_rw        = rw;
      next_burst     = burst;
      next_addr      = addr;
      next_pa_idx    = pa_idx;
      next_written   = written;
      next_rd_byte   = rd_byte;
      ev_fire        = 1'b0;
      ev_next        = '{kind: EV_CFG, addr: addr, data: rx};
      cfg_we         = 1'b0;
      pa_we          = 1'b0;
      // Nothing commits before the eighth bit, so deselect cancels
      if (bit_cnt == 3'h7) begin                            // R8
         if (!hdr_valid) begin
            if (rsp_is_stat(rx[ADDR_W-1:0]) && !rx[HDR_BURST_BIT]) begin
               ev_fire = 1'b1;                              // R12
               ev_next = '{kind: EV_STROBE,
                           addr: rx[ADDR_W-1:0], data: rx};
            end else begin
               next_hdr_valid = 1'b1;                       // R6
               next_rw        = rx[HDR_RW_BIT];
               next_burst     = rx[HDR_BURST_BIT];
               next_addr      = rx[ADDR_W-1:0];
            end
         end else begin
            if (!rw) begin
               if (addr <= CFG_LAST) begin
                  cfg_we  = 1'b1;                           // R5
                  ev_fire = 1'b1;
               end else if (addr == PA_ADDR) begin
                  pa_we   = 1'b1;                           // R20
                  ev_fire = 1'b1;
                  ev_next = '{kind: EV_PA,
                              addr: {3'h0, pa_idx}, data: rx};
               end else if (addr == FIFO_ADDR) begin
                  ev_fire = 1'b1;                           // R15
                  ev_next = '{kind: EV_FIFO, addr: addr, data: rx};
                  if (written < snap.free)
                     next_written = written + 7'h01;        // R17
               end
            end
            if (addr == PA_ADDR)
               next_pa_idx = pa_idx + 3'h1;                 // R19
            else if (burst && addr <= CFG_LAST)
               next_addr = addr + 6'h01;                    // R10
            // Status reads and non-burst accesses take one byte
            if (!burst || rsp_is_stat(addr))
               next_hdr_valid = 1'b0;                       // R16
         end
         next_rd_byte = rd_mux(next_addr, next_burst, next_pa_idx);
      end
      status_now = {snap.rdy_low, snap.state,
                    rsp_free_field(snap.free - written)};   // R3 R4
      // Reads echo status only on the header byte
      out_cur = (hdr_valid && rw) ? rd_byte : status_now;   // R9
   end

   always_ff @(posedge sclk or posedge csn) begin
      if (csn) begin
         bit_cnt   <= '0;
         shin      <= '0;
         hdr_valid <= 1'b0;
         rw        <= 1'b0;
         burst     <= 1'b0;
         addr      <= '0;
         pa_idx    <= '0;                                   // R19
         written   <= '0;
         rd_byte   <= '0;
      end else begin
         bit_cnt   <= next_bit_cnt;                         // R26
         shin      <= next_shin;
         hdr_valid <= next_hdr_valid;
         rw        <= next_rw;
         burst     <= next_burst;
         addr      <= next_addr;
         pa_idx    <= next_pa_idx;
         written   <= next_written;
         rd_byte   <= next_rd_byte;
      end
   end

   // Event toggle with bundled data; held eight link clocks per byte
   always_ff @(posedge sclk or posedge por) begin
      if (por) begin
         tog_link <= 1'b0;
         ev_link  <= '0;
      end else if (ev_fire) begin
         tog_link <= ~tog_link;
         ev_link  <= ev_next;
      end
   end

   always_ff @(posedge sclk or posedge cfg_rst) begin
      if (cfg_rst) begin
         for (int i = 0; i < CFG_REGS; i++)
            cfg_mem[i] <= CFG_RESET;
      end else if (cfg_we) begin
         cfg_mem[addr] <= rx;                               // R5
      end
   end

   always_ff @(posedge sclk or posedge pa_rst) begin
      if (pa_rst) begin
         for (int i = 0; i < PA_DEPTH; i++)
            pa_mem[i] <= PA_RESET;                          // R22
      end else if (pa_we) begin
         pa_mem[pa_idx] <= rx;
      end
   end

   // ------------------------------------------------------------
   // Serial output, driven on falling edges
   // ------------------------------------------------------------
   logic so_q, first_neg, next_so;

   always_comb begin
      next_so = out_cur[3'h7 - bit_cnt];                    // R1
   end

   always_ff @(negedge sclk or posedge csn) begin
      if (csn) begin
         so_q      <= 1'b0;
         first_neg <= 1'b0;
      end else begin
         so_q      <= next_so;                              // R26
         first_neg <= 1'b1;
      end
   end

   // Before the first falling edge the line shows ready directly
   assign so_out = first_neg ? so_q : rdy_q;                // R2

endmodule

// >>> common/rsp_pkg.sv
// Purpose: Shared constants and types for the radio serial port block
// Assumes: Host is the link master; header, data and strobe are bytes
// Notes:   Strobe codes other than those named here pass straight through
//
// Overview of operation
// R1: Status byte shifts out with every header
// R2: Status bit 7 is low-active oscillator ready
// R3: Status bits 6:4 carry main state code
// R4: Status bits 3:0 give free bytes, saturating
// R5: Configuration space 0x00-0x2E is read/write
// R6: Header holds direction, burst flag, address
// R7: Every link byte travels MSB first
// R8: Raised chip select cancels partial byte
// R9: Writes echo status per byte; reads only header
// R10: Burst address counter advances per byte
// R11: Burst flag splits status reads from strobes
// R12: Strobe is one header byte, no data
// R13: Host may chain accesses; waits after reset
// R14: Power-down and oscillator-off wait for deselect
// R15: Queue at 0x3F, single 0x3F, burst 0x7F
// R16: Single queue write is one byte; burst continues
// R17: Free count reported before current byte
// R18: Flush only in idle/underflow; sleep empties
// R19: Power table index wraps, clears on deselect
// R20: Burst and direction bits govern table access
// R21: Keying mode picks which table entries drive
// R22: Sleep discards power table contents
// R23: Host waits for ready low before clocking
// R24: Host retunes only while idle
// R25: Concurrent status reads may be corrupt
// R26: Sample on rising edge, drive on falling
package rsp_pkg;

   localparam int        ADDR_W        = 6;
   localparam int        FIFO_DEPTH    = 64;
   localparam int        CNT_W         = 7;
   localparam int        PA_DEPTH      = 8;
   localparam int        STAT_REGS     = 14;
   localparam int        CFG_REGS      = 47;
   localparam int        HDR_RW_BIT    = 7;
   localparam int        HDR_BURST_BIT = 6;
   localparam logic [5:0] CFG_LAST     = 6'h2E;
   localparam logic [5:0] STAT_FIRST   = 6'h30;
   localparam logic [5:0] STAT_LAST    = 6'h3D;
   localparam logic [5:0] PA_ADDR      = 6'h3E;
   localparam logic [5:0] FIFO_ADDR    = 6'h3F;
   localparam logic [5:0] STB_CHIP_RST = 6'h30;
   localparam logic [5:0] STB_OSC_OFF  = 6'h32;
   localparam logic [5:0] STB_PWR_DOWN = 6'h39;
   localparam logic [5:0] STB_FLUSH_TX = 6'h3B;
   localparam logic [7:0] CFG_RESET    = 8'h00;
   localparam logic [7:0] PA_RESET     = 8'h00;
   localparam logic [3:0] FREE_SAT     = 4'hF;
   localparam logic [CNT_W-1:0] FIFO_FULL = 7'h40;

   typedef enum logic [2:0] {
      RS_IDLE      = 3'b000,
      RS_TX        = 3'b010,
      RS_SYNTH_ON  = 3'b011,
      RS_CALIB     = 3'b100,
      RS_SETTLE    = 3'b101,
      RS_UNDERFLOW = 3'b111
   } rsp_state_e;

   typedef enum logic [1:0] {
      EV_CFG    = 2'b00,
      EV_STROBE = 2'b01,
      EV_FIFO   = 2'b10,
      EV_PA     = 2'b11
   } rsp_evt_e;

   typedef struct packed {
      rsp_evt_e          kind;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
   } rsp_evt_s;

   typedef struct packed {
      logic                      rdy_low;
      logic [2:0]                state;
      logic [CNT_W-1:0]          free;
      logic [STAT_REGS-1:0][7:0] stat;
   } rsp_snap_s;

   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
   } rsp_cfg_wr_s;

   // Free-space field of the status byte
   function automatic logic [3:0] rsp_free_field(input logic [CNT_W-1:0] n);
      rsp_free_field = (n >= CNT_W'(FREE_SAT)) ? FREE_SAT : n[3:0];
   endfunction

   function automatic logic rsp_is_stat(input logic [ADDR_W-1:0] a);
      rsp_is_stat = (a >= STAT_FIRST) && (a <= STAT_LAST);
   endfunction

endpackage

// >>> bench/rsp_port_asserts.sv
// Purpose: Port-level properties of the radio serial port
// Assumes: radio_state is held steady around strobes
// Notes:   Core clock domain only; link side is judged by the bench
module rsp_port_asserts
   import rsp_pkg::*;
(
   input wire logic              clock,
   input wire logic              nrst,
   input wire logic              csn,
   input wire logic [2:0]        radio_state,
   input wire logic              sleep_enter,
   input wire logic              tx_pop,
   input wire logic              so_oe,
   input wire rsp_cfg_wr_s       cfg_wr,
   input wire logic              strobe_valid,
   input wire logic [ADDR_W-1:0] strobe_code,
   input wire logic              flush_done,
   input wire logic              power_down_req,
   input wire logic              osc_off_req,
   input wire logic              chip_reset_req,
   input wire logic              tx_empty,
   input wire logic [7:0]        pa_level
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   // --------------------------------
   // Properties
   // --------------------------------
   // Four samples cover the worst sync lag of the enable
   deselect_quiet_a: assert property (csn[*4] |=> !so_oe)
      else $error("serial output driven while deselected");
   pd_deferred_a: assert property (power_down_req |-> csn && $past(csn))
      else $error("power-down request inside a frame");
   xoff_deferred_a: assert property (osc_off_req |-> csn && $past(csn))
      else $error("oscillator-off request inside a frame");
   flush_state_a: assert property (flush_done
      |-> radio_state inside {RS_IDLE, RS_UNDERFLOW})
      else $error("flush accepted in a busy state");
   flush_empty_a: assert property (flush_done |-> ##[0:2] tx_empty)
      else $error("queue not empty after flush");
   sleep_clear_a: assert property (sleep_enter
      |=> tx_empty ##[0:1] pa_level == PA_RESET)
      else $error("sleep left queue or power table");
   strobe_once_a: assert property (strobe_valid
      |-> rsp_is_stat(strobe_code) && !$past(strobe_valid))
      else $error("strobe pulse bad");
   cfg_write_a: assert property (cfg_wr.valid
      |-> (cfg_wr.addr <= CFG_LAST) ##1 !cfg_wr.valid)
      else $error("config write outside range or too long");
   empty_pop_a: assert property (tx_empty && tx_pop |=> tx_empty)
      else $error("pop from empty queue changed level");
   chip_rst_a: assert property (chip_reset_req
      |-> strobe_code == STB_CHIP_RST)
      else $error("bad reset code");
endmodule

bind rsp_port rsp_port_asserts rsp_port_asserts_i (
   .clock, .nrst, .csn, .radio_state, .sleep_enter, .tx_pop, .so_oe,
   .cfg_wr, .strobe_valid, .strobe_code, .flush_done, .power_down_req,
   .osc_off_req, .chip_reset_req, .tx_empty, .pa_level
);

// >>> bench/rsp_host.sv
// Purpose: Link master model driving frames into the serial port
// Assumes: Clock idles low and runs only inside frames, 30 ns period
// Notes:   Bytes are received MSB first and counted in n_rx
module rsp_host (
   output logic      sclk,
   output logic      csn,
   output logic      si,
   input  wire logic so_out,
   input  wire logic so_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0] rx;
   int         n_rx;
   logic       err = 1'b0;

   initial begin
      sclk = 1'b0;
      csn = 1'b1;
      si = 1'b1;
   end

   // Select, then hold the clock until ready reads low
   task automatic start;
      int k;
      csn = 1'b0;
      for (k = 0; k < 200; k++) begin
         #5;
         if (so_oe === 1'b1 && so_out === 1'b0)
            break;
      end
      if (k == 200)
         err = 1'b1;
   endtask

   // Drive in the low phase, sample on the rising edge
   task automatic xb(input logic [7:0] b, input int nb);
      int i;
      for (i = 7; i > 7 - nb; i--) begin
         si = b[i];
         #15 sclk = 1'b1;
         rx = {rx[6:0], so_out};
         #15 sclk = 1'b0;
      end
      if (nb == 8)
         n_rx++;
   endtask

   // Released data line never shows its last value
   task automatic stop;
      #15 csn = 1'b1;
      si = ~si;
      #150;
   endtask
endmodule

// >>> bench/rsp_port_test.sv
// Purpose: Self-checking bench for the radio serial port
// Assumes: Host model frames every access; core pops on demand
// Notes:   Expected link bytes, writes and pops are queued and compared
module rsp_port_test
   import rsp_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;

   logic clock, nrst, osc_ready_low, sleep_enter, tx_pop, ook_mode, ook_bit;
   logic [2:0]                radio_state, power_select_field;
   logic [STAT_REGS-1:0][7:0] status_regs;
   wire logic                 sclk, csn, si, so_out, so_oe, strobe_valid;
   logic flush_done, power_down_req, osc_off_req, chip_reset_req, tx_empty;
   wire logic [ADDR_W-1:0]    strobe_code;
   wire logic [7:0]           tx_data, pa_level;
   rsp_cfg_wr_s               cfg_wr;
   int                        n_fail = 0;
   int                        n_checks = 0;
   int                        fcnt, fr, wr, k;
   logic [15:0]               seed = 16'h000F;
   logic [7:0]                b, pa [8];
   logic                      pop_d;
   logic [13:0]               exp_cfg [$];
   logic [7:0]                exp_so [$], exp_tx [$];
   rsp_state_e codes [6] = '{RS_IDLE, RS_TX, RS_SYNTH_ON, RS_CALIB,
                             RS_SETTLE, RS_UNDERFLOW};

   rsp_port rsp_port_i (.clock, .nrst, .sclk, .csn, .si, .osc_ready_low,
      .radio_state, .status_regs, .sleep_enter, .tx_pop, .ook_mode, .ook_bit,
      .power_select_field, .so_out, .so_oe, .cfg_wr, .strobe_valid,
      .strobe_code, .flush_done, .power_down_req, .osc_off_req,
      .chip_reset_req, .tx_data, .tx_empty, .pa_level);
   rsp_host rsp_host_i (.sclk, .csn, .si, .so_out, .so_oe);

   // --------------------------------
   // Helpers
   // --------------------------------
   function automatic logic [7:0] stat;
      int f;
      f = fr - wr;
      return {1'b0, radio_state, (f >= 15) ? 4'hF : 4'(f)};
   endfunction
   function automatic logic [7:0] rnd;
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed[7:0];
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic report_and_stop;
      if (n_fail == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Free count is frozen when the frame opens
   task automatic go;
      fr = 64 - fcnt;
      wr = 0;
      rsp_host_i.start();
   endtask
   task automatic wb(input logic [7:0] d, input logic [7:0] e);
      exp_so.push_back(e);
      rsp_host_i.xb(d, 8);
   endtask

   always @(rsp_host_i.n_rx)
      chk("so", {8'h00, exp_so.pop_front()}, {8'h00, rsp_host_i.rx});
   always @(posedge clock) begin
      if (cfg_wr.valid === 1'b1)
         chk("cfg", {2'b00, exp_cfg.pop_front()},
             {2'b00, cfg_wr.addr, cfg_wr.data});
      if (pop_d)
         chk("tx", {8'h00, exp_tx.pop_front()}, {8'h00, tx_data});
      pop_d <= (tx_pop && tx_empty === 1'b0);
   end
   always @(posedge rsp_host_i.err) begin
      n_fail++;
      report_and_stop();
   end

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // --------------------------------
   // Scenarios
   // --------------------------------
   initial begin
      nrst = 1'b0;
      osc_ready_low = 1'b1;
      {sleep_enter, tx_pop, ook_mode, ook_bit} = 4'h0;
      power_select_field = 3'h0;
      radio_state = RS_IDLE;
      fcnt = 0;
      for (k = 0; k < STAT_REGS; k++)
         status_regs[k] = rnd();
      cyc(5);
      nrst = 1'b1;
      osc_ready_low = 1'b0;
      cyc(4);
      foreach (codes[i]) begin
         radio_state = codes[i];
         go();
         wb(8'h3B, stat());
         rsp_host_i.stop();
      end
      radio_state = RS_IDLE;
      go();
      wb(8'h05, stat());
      wb(8'hA5, stat());
      exp_cfg.push_back({6'h05, 8'hA5});
      rsp_host_i.stop();
      go();
      wb(8'h06, stat());
      rsp_host_i.xb(8'h5A, 4);
      rsp_host_i.stop();
      go();
      wb(8'hC5, stat());
      wb(8'h00, 8'hA5);
      wb(8'h00, CFG_RESET);
      rsp_host_i.stop();
      go();
      wb(8'h6D, stat());
      for (k = 0; k < 3; k++) begin
         b = rnd();
         wb(b, stat());
         if (k < 2)
            exp_cfg.push_back({6'(45 + k), b});
      end
      rsp_host_i.stop();
      for (k = 0; k < STAT_REGS; k++) begin
         go();
         wb(8'hF0 + 8'(k), stat());
         wb(8'h00, status_regs[k]);
         rsp_host_i.stop();
      end
      go();
      wb(8'h30, stat());
      wb(8'h39, stat());
      wb(8'h32, stat());
      rsp_host_i.stop();
      go();
      wb(8'h7F, stat());
      for (k = 0; k < 65; k++) begin
         b = rnd();
         wb(b, stat());
         if (k < 64) begin
            exp_tx.push_back(b);
            wr++;
         end
      end
      rsp_host_i.stop();
      fcnt = 64;
      go();
      wb(8'h3F, stat());
      wb(8'hEE, stat());
      rsp_host_i.stop();
      cyc(1);
      tx_pop = 1'b1;
      cyc(65);
      tx_pop = 1'b0;
      fcnt = 0;
      go();
      wb(8'h3F, stat());
      wb(8'h77, stat());
      wr++;
      wb(8'h3F, stat());
      wb(8'h78, stat());
      wb(8'h3B, stat());
      rsp_host_i.stop();
      go();
      wb(8'h7E, stat());
      for (k = 0; k < 9; k++) begin
         b = rnd();
         pa[k % 8] = b;
         wb(b, stat());
      end
      rsp_host_i.stop();
      go();
      wb(8'hFE, stat());
      for (k = 0; k < 9; k++)
         wb(8'h00, pa[k % 8]);
      rsp_host_i.stop();
      cyc(3);
      chk("pa0", 16'(pa[0]), 16'(pa_level));
      {ook_mode, ook_bit} = 2'b11;
      power_select_field = 3'h5;
      cyc(3);
      chk("pasel", 16'(pa[5]), 16'(pa_level));
      sleep_enter = 1'b1;
      cyc(1);
      sleep_enter = 1'b0;
      cyc(3);
      chk("pasleep", 16'(PA_RESET), 16'(pa_level));
      chk("left", 16'h0000, 16'(exp_cfg.size() + exp_tx.size()));
      report_and_stop();
   end
endmodule
